// ==== shared/internal_stable_flag_pkg.sv ====
/*
  Constants for the internal clock generator settle and trim block.
  Assumes a single 20 MHz clock domain; all times become cycle counts here.
*/
package internal_stable_flag_pkg;
  localparam int unsigned CLK_HZ            = 20_000_000;
  localparam int unsigned BASE_HZ           = 307_200;
  // Cycles of clock_i per base-clock period, rounded down
  localparam int unsigned BASE_DIV          = CLK_HZ / BASE_HZ;
  localparam int unsigned CORR_BASE_PERIODS = 4;
  localparam int unsigned FINE_MAX_CORR     = 8;
  localparam int unsigned MIN_MAX_CORR      = 24;
  localparam int unsigned CAP_TOTAL_UNITS   = 639;
  localparam int unsigned CAP_FIXED_UNITS   = 384;
  localparam int unsigned CAP_TRIM_UNITS    = 255;
  localparam logic [7:0]  TRIM_RESET        = 8'h80;
  localparam logic [6:0]  MULT_RESET        = 7'h15;
  localparam logic [9:0]  CAP_RESET_UNITS   = 10'h200;
  localparam int unsigned XTAL_STAB_CYCLES  = 4096;
  localparam int unsigned EXT_STAB_CYCLES   = 16;
  // Error thresholds in tenths of a percent
  localparam logic [9:0]  ERR_COARSE_LIMIT  = 10'h096;
  localparam logic [9:0]  ERR_STABLE_LIMIT  = 10'h032;
  // Frequency step per trim unit, thousandths of a percent
  localparam int unsigned TRIM_STEP_MPCT    = 195;
  // Monitor ranges in Hz
  localparam int unsigned MON_XTAL_LO_MIN   = 30_000;
  localparam int unsigned MON_XTAL_LO_MAX   = 100_000;
  localparam int unsigned MON_XTAL_HI_MIN   = 1_000_000;
  localparam int unsigned MON_XTAL_HI_MAX   = 8_000_000;
  localparam int unsigned MON_EXT_MIN       = 60;
  localparam int unsigned MON_EXT_MAX       = 32_000_000;
  localparam int unsigned MON_SLOW_MAX      = 307_200;

  typedef enum logic [3:0] {
    PH_IDLE   = 4'b0001,
    PH_COARSE = 4'b0010,
    PH_FINE   = 4'b0100,
    PH_MIN    = 4'b1000
  } internal_stable_flag_phase_t;
endpackage

// ==== hdl/internal_stable_flag_ext_stab.sv ====
/*
  External clock stabilization divider: counts sampled edges of the
  external clock and flags stable after the configured count.
  Assumes the edge pulse is already synchronised to clock_i.
*/
`timescale 1ns/1ns
module internal_stable_flag_ext_stab
  import internal_stable_flag_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic clear_i,
  input  wire logic crystal_option_i,
  input  wire logic edge_i,
  output logic      stable_o
);
  logic [12:0] count_ff;
  logic [12:0] nxt_count;
  logic        stable_ff;
  wire  [12:0] limit = crystal_option_i ? 13'(XTAL_STAB_CYCLES) : 13'(EXT_STAB_CYCLES);
  wire         reach = edge_i && (count_ff + 13'h0001 >= limit);

  assign nxt_count = clear_i ? 13'h0000 :
                     (edge_i && !stable_ff) ? count_ff + 13'h0001 : count_ff;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      count_ff  <= 13'h0000;
      stable_ff <= 1'b0;
    end else begin
      count_ff  <= nxt_count;
      stable_ff <= clear_i ? 1'b0 : (stable_ff | reach);
    end
  end
  assign stable_o = stable_ff;
endmodule

// ==== hdl/internal_stable_flag_top.sv ====
/*
  Settle, trim and low-power control of the internal clock generator:
  loop filter pacing and phases, stable flags, trim capacitor, stop/wait
  handling and the four configuration options.
  Assumes one 20 MHz clock; the period error estimate comes from the
  frequency comparator as a magnitude in tenths of a percent.
*/
// Behaviour
// - leave coarse correction below fifteen percent
// - fine steps, at most eight to five; code does not limit the fine step count
// - one correction per four base periods
// - set internal stable within five percent
// - minimum steps, at most twenty-four more; code keeps minimum steps without limit
// - capacitor 384 fixed plus trim units
// - trim resets to 128, capacitor 512
// - each trim unit shifts frequency 0.195 percent
// - generator keeps running in wait mode
// - stop without option halts, clocks low
// - stop with option runs, no wake
// - stop without option clears stable flags and monitor
// - stop keeps selects, external enable, trim, divider
// - no external option blocks external enable
// - amplifier drives only with all three set
// - crystal option chooses monitor range
// - stabilization after 4096 or 16 cycles
// - slow option cuts drive, lowers range
// - all four options clear by default
// - internal clock is multiplier times base
// - multiplier/trim write or inactivity clears stable
`timescale 1ns/1ns
module internal_stable_flag_top
  import internal_stable_flag_pkg::*;
#(
  parameter int unsigned MULT_W = 7,
  parameter int unsigned TRIM_W = 8
) (
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic              external_clock_option_i,
  input  wire logic              crystal_option_i,
  input  wire logic              slow_external_option_i,
  input  wire logic              run_in_stop_option_i,
  input  wire logic              stop_i,
  input  wire logic              wait_i,
  input  wire logic              mult_wr_i,
  input  wire logic [MULT_W-1:0] mult_wdata_i,
  input  wire logic              trim_wr_i,
  input  wire logic [TRIM_W-1:0] trim_wdata_i,
  input  wire logic              ext_gen_enable_wr_i,
  input  wire logic              ext_gen_enable_wdata_i,
  input  wire logic              internal_gen_enable_i,
  input  wire logic              clock_select_i,
  input  wire logic              monitor_enable_wr_i,
  input  wire logic              monitor_enable_wdata_i,
  input  wire logic              monitor_irq_enable_wr_i,
  input  wire logic              monitor_irq_enable_wdata_i,
  input  wire logic              monitor_inactive_i,
  input  wire logic              internal_inactive_i,
  input  wire logic [9:0]        period_error_i,
  input  wire logic              error_sign_i,
  input  wire logic              external_clock_i,
  input  wire logic              irq_pending_i,
  output logic                   internal_stable_flag_o,
  output logic                   external_stable_flag_o,
  output logic                   monitor_enable_o,
  output logic                   monitor_irq_enable_o,
  output logic                   monitor_flag_o,
  output logic                   external_gen_enable_o,
  output logic [MULT_W-1:0]      mult_o,
  output logic [TRIM_W-1:0]      trim_o,
  output logic [9:0]             cap_units_o,
  output logic [11:0]            oscillator_stage_ctrl_o,
  output logic                   correct_o,
  output logic                   correct_up_o,
  output logic [3:0]             phase_o,
  output logic                   base_tick_o,
  output logic                   clocks_run_o,
  output logic                   osc_input_is_port_o,
  output logic                   osc_output_drive_o,
  output logic                   reduced_drive_o,
  output logic                   mon_xtal_range_o,
  output logic                   mon_slow_range_o,
  output logic                   wake_o
);
  // Option capture one cycle after reset release
  logic [3:0] opt_ff;
  logic       opt_taken_ff;
  wire  ext_opt  = opt_ff[0];
  wire  xtal_opt = opt_ff[1];
  wire  slow_opt = opt_ff[2];
  wire  run_opt  = opt_ff[3];

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      opt_ff       <= 4'h0;
      opt_taken_ff <= 1'b0;
    end else if (!opt_taken_ff) begin
      opt_ff       <= {run_in_stop_option_i, slow_external_option_i,
                       crystal_option_i, external_clock_option_i};
      opt_taken_ff <= 1'b1;
    end
  end

  wire halted   = stop_i && !run_opt;
  wire gen_run  = internal_gen_enable_i && !halted;
  assign clocks_run_o = !halted;
  assign wake_o = irq_pending_i && wait_i && !stop_i;

  // Multiplier and trim hold through stop
  logic [MULT_W-1:0] mult_ff;
  logic [TRIM_W-1:0] trim_ff;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mult_ff <= MULT_W'(MULT_RESET);
      trim_ff <= TRIM_W'(TRIM_RESET);
    end else begin
      if (mult_wr_i)
        mult_ff <= mult_wdata_i;
      if (trim_wr_i)
        trim_ff <= trim_wdata_i;
    end
  end
  assign mult_o      = mult_ff;
  assign trim_o      = trim_ff;
  assign cap_units_o = 10'(CAP_FIXED_UNITS) + 10'(trim_ff);

  // Base-clock tick from the system clock
  logic [6:0] base_cnt_ff;
  wire        base_tick = gen_run && (base_cnt_ff == 7'(BASE_DIV - 1));
  always_ff @(posedge clock_i) begin
    if (rst_i || !gen_run)
      base_cnt_ff <= 7'h00;
    else
      base_cnt_ff <= base_tick ? 7'h00 : base_cnt_ff + 7'h01;
  end
  assign base_tick_o = base_tick;

  // Correction pacing and phase tracking
  internal_stable_flag_phase_t phase_ff;
  internal_stable_flag_phase_t nxt_phase;
  logic [1:0]  pace_ff;
  logic [4:0]  ncorr_ff;
  logic        istable_ff;
  logic [11:0] stage_ff;
  wire         restart  = mult_wr_i || trim_wr_i || internal_inactive_i || halted
                          || !internal_gen_enable_i;
  wire         corr_now = base_tick && (pace_ff == 2'(CORR_BASE_PERIODS - 1));
  wire         in_coarse = period_error_i >= ERR_COARSE_LIMIT;
  wire         in_fine   = !in_coarse && period_error_i >= ERR_STABLE_LIMIT;

  always_comb begin
    nxt_phase = phase_ff;
    case (phase_ff)
      PH_IDLE:   nxt_phase = PH_COARSE;
      PH_COARSE: if (corr_now && !in_coarse) nxt_phase = PH_FINE;
      PH_FINE:   if (corr_now && !in_fine && !in_coarse) nxt_phase = PH_MIN;
      PH_MIN:    if (corr_now && in_coarse) nxt_phase = PH_COARSE;
      default:   nxt_phase = PH_IDLE;
    endcase
  end

  // Step size per phase in stage-control units
  function automatic logic [11:0] step_of(input internal_stable_flag_phase_t ph);
    case (ph)
      PH_COARSE: step_of = 12'h020;
      PH_FINE:   step_of = 12'h008;
      PH_MIN:    step_of = 12'h001;
      default:   step_of = 12'h000;
    endcase
  endfunction

  wire [11:0] step = step_of(phase_ff);
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      phase_ff   <= PH_IDLE;
      pace_ff    <= 2'h0;
      ncorr_ff   <= 5'h00;
      istable_ff <= 1'b0;
      stage_ff   <= 12'h000;
    end else if (restart) begin
      phase_ff   <= PH_IDLE;
      pace_ff    <= 2'h0;
      ncorr_ff   <= 5'h00;
      istable_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      if (base_tick)
        pace_ff <= pace_ff + 2'h1;
      if (corr_now) begin
        stage_ff <= error_sign_i ? stage_ff - step : stage_ff + step;
        ncorr_ff <= (nxt_phase != phase_ff) ? 5'h00 : ncorr_ff + 5'h01;
        istable_ff <= (nxt_phase == PH_MIN);
      end
    end
  end
  assign correct_o               = corr_now;
  assign correct_up_o            = !error_sign_i;
  assign phase_o                 = phase_ff;
  assign oscillator_stage_ctrl_o = stage_ff;
  assign internal_stable_flag_o  = istable_ff;

  // External enable gated by the external-clock option
  logic ecg_ff;
  always_ff @(posedge clock_i) begin
    if (rst_i)
      ecg_ff <= 1'b0;
    else if (!ext_opt)
      ecg_ff <= 1'b0;
    else if (ext_gen_enable_wr_i)
      ecg_ff <= ext_gen_enable_wdata_i;
  end
  assign external_gen_enable_o = ecg_ff;
  assign osc_input_is_port_o   = !(ext_opt && ecg_ff);
  assign osc_output_drive_o    = xtal_opt && ext_opt && ecg_ff;
  assign reduced_drive_o       = slow_opt && osc_output_drive_o;
  assign mon_xtal_range_o      = xtal_opt;
  assign mon_slow_range_o      = slow_opt;

  // External clock pin synchroniser, change valid when stages 2 and 3 agree
  logic [2:0] ext_sync_ff;
  logic       ext_prev_ff;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ext_sync_ff <= 3'h0;
      ext_prev_ff <= 1'b0;
    end else begin
      ext_sync_ff <= {ext_sync_ff[1:0], external_clock_i};
      if (ext_sync_ff[2] == ext_sync_ff[1])
        ext_prev_ff <= ext_sync_ff[2];
    end
  end
  wire ext_rise = (ext_sync_ff[2] == ext_sync_ff[1]) && ext_sync_ff[2] && !ext_prev_ff;

  internal_stable_flag_ext_stab u_ext_stab (
    .clock_i          (clock_i),
    .rst_i            (rst_i),
    .clear_i          (!ecg_ff || halted || monitor_inactive_i),
    .crystal_option_i (xtal_opt),
    .edge_i           (ext_rise),
    .stable_o         (external_stable_flag_o)
  );

  // Clock monitor enable, interrupt enable and flag
  logic mon_ff;
  logic mie_ff;
  logic mflag_ff;
  wire  mon_kill = halted || !ecg_ff || !internal_gen_enable_i;
  always_ff @(posedge clock_i) begin
    if (rst_i || mon_kill) begin
      mon_ff   <= 1'b0;
      mie_ff   <= 1'b0;
      mflag_ff <= 1'b0;
    end else begin
      if (monitor_enable_wr_i && !mflag_ff)
        mon_ff <= monitor_enable_wdata_i && istable_ff && external_stable_flag_o;
      if (!mon_ff)
        mie_ff <= 1'b0;
      else if (monitor_irq_enable_wr_i)
        mie_ff <= monitor_irq_enable_wdata_i;
      mflag_ff <= mon_ff && (mflag_ff || monitor_inactive_i || internal_inactive_i);
    end
  end
  assign monitor_enable_o     = mon_ff;
  assign monitor_irq_enable_o = mie_ff;
  assign monitor_flag_o       = mflag_ff;
endmodule

// ==== tb/internal_stable_flag_properties.sv ====
/* Port checker for internal_stable_flag_top.
   Bound to every internal_stable_flag_top; sees only its ports. */
`timescale 1ns/1ns
module internal_stable_flag_properties
  import internal_stable_flag_pkg::*;
#(parameter int unsigned MULT_W = 7, parameter int unsigned TRIM_W = 8) (
  input wire logic clock_i, rst_i, external_clock_option_i, crystal_option_i,
  input wire logic slow_external_option_i, run_in_stop_option_i, stop_i, wait_i,
  input wire logic mult_wr_i, trim_wr_i, irq_pending_i,
  input wire logic internal_stable_flag_o, external_stable_flag_o, monitor_enable_o,
  input wire logic monitor_irq_enable_o, monitor_flag_o, external_gen_enable_o,
  input wire logic [MULT_W-1:0] mult_o,
  input wire logic [TRIM_W-1:0] trim_o,
  input wire logic [9:0] cap_units_o,
  input wire logic [3:0] phase_o,
  input wire logic base_tick_o, clocks_run_o, osc_input_is_port_o, osc_output_drive_o,
  input wire logic reduced_drive_o, mon_xtal_range_o, mon_slow_range_o, wake_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_cap; cap_units_o == 10'(CAP_FIXED_UNITS + trim_o); endproperty
  a_cap: assert property (p_cap) else $error("capacitor units off");
  property p_rst; $past(rst_i) |-> trim_o == TRIM_RESET && mult_o == MULT_RESET
    && cap_units_o == CAP_RESET_UNITS && !external_gen_enable_o; endproperty
  a_rst: assert property (p_rst) else $error("reset values off");
  property p_wr; trim_wr_i || mult_wr_i |=> !internal_stable_flag_o && phase_o == PH_IDLE;
  endproperty
  a_wr: assert property (p_wr) else $error("stable kept after write");
  property p_stb; $rose(internal_stable_flag_o) |-> phase_o == PH_MIN; endproperty
  a_stb: assert property (p_stb) else $error("stable set off phase");
  property p_tick; base_tick_o |-> ##1 (!base_tick_o) [*8] ##57
    (base_tick_o || !clocks_run_o); endproperty
  a_tick: assert property (p_tick) else $error("base tick spacing");
  property p_stop; stop_i && !run_in_stop_option_i && !$past(rst_i) |-> !clocks_run_o ##1
    !(internal_stable_flag_o || external_stable_flag_o || monitor_enable_o
    || monitor_irq_enable_o || monitor_flag_o); endproperty
  a_stop: assert property (p_stop) else $error("stop did not halt");
  property p_run; stop_i && run_in_stop_option_i && !$past(rst_i) |-> clocks_run_o && !wake_o;
  endproperty
  a_run: assert property (p_run) else $error("stop with run option");
  property p_keep; stop_i && !trim_wr_i && !mult_wr_i |=> $stable(trim_o) && $stable(mult_o);
  endproperty
  a_keep: assert property (p_keep) else $error("stop changed setting");
  property p_ext; !$past(rst_i) && !external_clock_option_i |-> !external_gen_enable_o
    && osc_input_is_port_o; endproperty
  a_ext: assert property (p_ext) else $error("external path open");
  property p_drv; !$past(rst_i) |-> osc_output_drive_o == (crystal_option_i
    && external_clock_option_i && external_gen_enable_o); endproperty
  a_drv: assert property (p_drv) else $error("amplifier drive off");
  property p_mon; !$past(rst_i) |-> mon_xtal_range_o == crystal_option_i
    && mon_slow_range_o == slow_external_option_i
    && reduced_drive_o == (slow_external_option_i && osc_output_drive_o); endproperty
  a_mon: assert property (p_mon) else $error("monitor range off");
  property p_wake; wait_i && !stop_i && irq_pending_i |-> wake_o; endproperty
  a_wake: assert property (p_wake) else $error("no wake in wait");
endmodule
bind internal_stable_flag_top internal_stable_flag_properties #(.MULT_W(MULT_W), .TRIM_W(TRIM_W)) u_props (.*);

// ==== tb/internal_stable_flag_ext_src.sv ====
/* External clock source on the oscillator input pin.
   Runs only while the external generator is enabled. */
`timescale 1ns/1ns
module internal_stable_flag_ext_src #(parameter int HALF_NS = 100) (
  input  wire logic enable_i,
  output logic      clock_o
);
  // Stands low while the generator is off
  initial begin
    clock_o = 1'b0;
    forever #HALF_NS clock_o = enable_i ? ~clock_o : 1'b0;
  end
endmodule

// ==== tb/internal_stable_flag_top_tb.sv ====
/* Self-checking bench for internal_stable_flag_top with an external clock source.
   Inputs move 5 ns after each rising clock edge. */
`timescale 1ns/1ns
module internal_stable_flag_top_tb;
  import internal_stable_flag_pkg::*;
  logic clock_i, rst_i, external_clock_option_i, crystal_option_i, slow_external_option_i;
  logic run_in_stop_option_i, stop_i, wait_i, mult_wr_i, trim_wr_i, ext_gen_enable_wr_i;
  logic ext_gen_enable_wdata_i, internal_gen_enable_i, clock_select_i, monitor_enable_wr_i;
  logic monitor_enable_wdata_i, monitor_irq_enable_wr_i, monitor_irq_enable_wdata_i;
  logic monitor_inactive_i, internal_inactive_i, error_sign_i, external_clock_i;
  logic irq_pending_i, internal_stable_flag_o, external_stable_flag_o, monitor_enable_o;
  logic monitor_irq_enable_o, monitor_flag_o, external_gen_enable_o, correct_o, wake_o;
  logic correct_up_o, base_tick_o, clocks_run_o, osc_input_is_port_o, osc_output_drive_o;
  logic reduced_drive_o, mon_xtal_range_o, mon_slow_range_o;
  logic [6:0]  mult_wdata_i, mult_o;
  logic [7:0]  trim_wdata_i, trim_o;
  logic [9:0]  period_error_i, cap_units_o;
  logic [11:0] oscillator_stage_ctrl_o;
  logic [3:0]  phase_o;
  int          err_total, samples_checked;

  internal_stable_flag_top uut (.*);
  internal_stable_flag_ext_src u_src (.enable_i(external_gen_enable_o), .clock_o(external_clock_i));

  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #5;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask

  task automatic wait_hi(ref logic s, input int n);
    for (int i = 0; i < n && s !== 1'b1; i++) cyc(1);
  endtask

  task automatic reset(input logic [3:0] o);
    {external_clock_option_i, crystal_option_i, slow_external_option_i} = o[3:1];
    run_in_stop_option_i = o[0];
    {stop_i, wait_i, mult_wr_i, trim_wr_i, ext_gen_enable_wr_i, clock_select_i} = '0;
    {monitor_enable_wr_i, monitor_irq_enable_wr_i, monitor_inactive_i} = '0;
    {internal_inactive_i, error_sign_i, irq_pending_i, internal_gen_enable_i} = 4'h1;
    {ext_gen_enable_wdata_i, monitor_enable_wdata_i, monitor_irq_enable_wdata_i} = 3'h7;
    {mult_wdata_i, trim_wdata_i, period_error_i} = '0;
    rst_i = 1'b1;
    cyc(4);
    rst_i = 1'b0;
    cyc(2);
  endtask

  task automatic settle();
    int n;
    logic [11:0] s0;
    period_error_i = 10'h0C8;
    trim_wdata_i = 8'h80;
    pulse(trim_wr_i);
    chk(internal_stable_flag_o, 1'b0);
    chk(phase_o, PH_IDLE);
    cyc(1);
    chk(phase_o, PH_COARSE);
    cyc(600);
    chk(phase_o, PH_COARSE);
    period_error_i = 10'h064;
    error_sign_i = 1'b1;
    for (n = 0; n < 1500 && phase_o !== PH_FINE; n++) cyc(1);
    chk(phase_o, PH_FINE);
    wait_hi(correct_o, 600);
    s0 = oscillator_stage_ctrl_o;
    for (n = 1; n < 600; n++) begin
      cyc(1);
      if (correct_o === 1'b1) break;
    end
    chk(16'(n), 16'h0104);
    chk(oscillator_stage_ctrl_o, s0 - 12'h008);
    chk(correct_up_o, 1'b0);
    chk(internal_stable_flag_o, 1'b0);
    period_error_i = 10'h028;
    wait_hi(internal_stable_flag_o, 1500);
    chk({phase_o, internal_stable_flag_o}, 5'h11);
  endtask

  task automatic mon_on();
    pulse(monitor_enable_wr_i);
    pulse(monitor_irq_enable_wr_i);
    chk({monitor_enable_o, monitor_irq_enable_o}, 2'h3);
  endtask

  initial begin
    err_total = 0;
    samples_checked = 0;
    reset(4'h0);
    chk({trim_o, mult_o}, 15'h4015);
    chk(cap_units_o, 10'h200);
    chk({osc_input_is_port_o, osc_output_drive_o, mon_xtal_range_o, mon_slow_range_o}, 4'h8);
    trim_wdata_i = 8'hFF;
    pulse(trim_wr_i);
    chk(cap_units_o, 10'h27F);
    cyc(1);
    trim_wdata_i = 8'h00;
    pulse(trim_wr_i);
    chk(cap_units_o, 10'h180);
    pulse(ext_gen_enable_wr_i);
    chk(external_gen_enable_o, 1'b0);
    settle();
    mult_wdata_i = 7'h2A;
    pulse(mult_wr_i);
    chk({mult_o, internal_stable_flag_o}, 8'h54);
    wait_i = 1'b1;
    cyc(1);
    chk(wake_o, 1'b0);
    irq_pending_i = 1'b1;
    cyc(1);
    chk(wake_o, 1'b1);
    reset(4'hF);
    pulse(ext_gen_enable_wr_i);
    chk({osc_output_drive_o, osc_input_is_port_o, mon_xtal_range_o}, 3'h5);
    chk({mon_slow_range_o, reduced_drive_o}, 2'h3);
    cyc(2000);
    chk(external_stable_flag_o, 1'b0);
    wait_hi(external_stable_flag_o, 18000);
    chk(external_stable_flag_o, 1'b1);
    settle();
    mon_on();
    monitor_inactive_i = 1'b1;
    cyc(3);
    monitor_enable_wdata_i = 1'b0;
    pulse(monitor_enable_wr_i);
    chk({monitor_flag_o, monitor_enable_o}, 2'h3);
    {stop_i, monitor_inactive_i, irq_pending_i} = 3'h5;
    cyc(3);
    chk({clocks_run_o, wake_o, internal_stable_flag_o}, 3'h5);
    stop_i = 1'b0;
    internal_inactive_i = 1'b1;
    cyc(2);
    chk(internal_stable_flag_o, 1'b0);
    reset(4'h8);
    pulse(ext_gen_enable_wr_i);
    chk({osc_output_drive_o, mon_xtal_range_o}, 2'h0);
    wait_hi(external_stable_flag_o, 200);
    chk(external_stable_flag_o, 1'b1);
    settle();
    mon_on();
    stop_i = 1'b1;
    cyc(2);
    chk(clocks_run_o, 1'b0);
    chk({internal_stable_flag_o, external_stable_flag_o, monitor_enable_o,
         monitor_irq_enable_o, monitor_flag_o}, 5'h00);
    chk({trim_o, mult_o, external_gen_enable_o}, 16'h802B);
    complete_run();
  end

  initial begin
    #4000000;
    err_total++;
    complete_run();
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
endmodule
